// ===== dic_pkg.sv
// Purpose: Shared constants and types for the digital input conditioning block
// Assumes: 10 MHz core clock, AHB-Lite register access, word registers
// Notes: Register indices are word indices; byte address is four times the index
package dic_pkg;
  // Sampling time and clock rate
  localparam int SAMPLE_PERIOD_NS = 1_000_000;
  localparam int CLK_PERIOD_NS = 100;
  localparam int TICK_CYCLES_DEF = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
  localparam int PRESC_W = 16;
  // Bit layout of summary and output words
  localparam int WORD_W = 32;
  localparam int LEVEL_BASE = 16;
  localparam int SF_NEG_LIMIT = 0;
  localparam int SF_POS_LIMIT = 1;
  localparam int SF_HOME = 2;
  localparam int BRAKE_BIT = 0;
  localparam int THR_INPUTS = 4;
  localparam int ROUTE_ENTRIES = 32;
  localparam int PHYS_MAX = 16;
  localparam int EXT_W = 6;
  localparam int CODE_INV_BIT = 7;
  localparam int ROUTING_EN_BIT = 0;
  // Register word indices
  localparam logic [7:0] IDX_SFE = 8'h00;
  localparam logic [7:0] IDX_INV = 8'h01;
  localparam logic [7:0] IDX_FEN = 8'h02;
  localparam logic [7:0] IDX_FVAL = 8'h03;
  localparam logic [7:0] IDX_RAW = 8'h04;
  localparam logic [7:0] IDX_THR = 8'h05;
  localparam logic [7:0] IDX_RTEN = 8'h07;
  localparam logic [7:0] IDX_SUMM = 8'h08;
  localparam logic [7:0] IDX_OUTC = 8'h09;
  localparam logic [7:0] IDX_PRESC = 8'h0A;
  localparam logic [7:0] IDX_ROUTE_FIRST = 8'h41;
  localparam logic [7:0] IDX_ROUTE_LAST = 8'h60;
  localparam logic [7:0] IDX_NONE = 8'hFF;
  // Route source codes, low seven bits
  localparam logic [6:0] SRC_ZERO = 7'h00;
  localparam logic [6:0] SRC_PHYS_FIRST = 7'h01;
  localparam logic [6:0] SRC_PHYS_LAST = 7'h10;
  localparam logic [6:0] SRC_HALL_U = 7'h41;
  localparam logic [6:0] SRC_ENC_IDX = 7'h46;
  localparam logic [6:0] SRC_NET = 7'h48;
  // Reset values
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;
  localparam logic [7:0] CODE_RESET = 8'h00;
  localparam logic HRESP_OKAY = 1'b0;
  // Register decode result
  typedef enum logic [3:0] {
    REG_NONE, REG_SFE, REG_INV, REG_FEN, REG_FVAL, REG_RAW, REG_THR,
    REG_RTEN, REG_SUMM, REG_OUTC, REG_PRESC, REG_ROUTE
  } dic_reg_e;
endpackage

// ===== dic_top.sv
// Purpose: Digital input conditioning, input routing and output mapping
// Assumes: One 10 MHz clock; pins and Hall/encoder lines are asynchronous
// Notes: Summary word changes only on the sampling tick
// Function
// - Sample every input once per 1 ms tick; shorter pulses are missed unless they span a tick.
// - Special bits 0,1,2 are negative limit, positive limit, home from inputs 1-3.
// - Enable mask gates special bits only; level bits 16-31 unaffected.
// - Invert bit 0 gives normally open, 1 gives normally closed polarity.
// - Force enable replaces the sampled level with the software value.
// - Forced input takes its bit of the force value mask.
// - Raw register shows sampled levels without forcing, inversion or masking.
// - Threshold mask bits drive inputs 1-4: 0 is 5 V, 1 is 24 V.
// - Input 1 conditioned value in summary bit 16, special view in bit 0.
// - Writing routing enable 1 enters routing mode; clearing it leaves.
// - Routing mode ignores enable, invert, force enable and force value masks.
// - Entering routing loads route table to reproduce previous behaviour.
// - In routing mode summary bit n comes from route entry n+1.
// - Codes: 00 zero, 01-10 inputs, 41-46 Hall/encoder, 48 network active.
// - Code bit 7 inverts the source; 80 gives constant one.
// - Output k driven from output control bit 15+k.
// - Output control bit 0 drives the brake output.
// - Each input has a special bit 0-15 and a level bit 16-31.
`timescale 1ns/1ps
module dic_top #(
  parameter int NUM_IN = 6,
  parameter int NUM_OUT = 4,
  parameter int TICK_CYCLES = dic_pkg::TICK_CYCLES_DEF
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [NUM_IN-1:0] din_pin,
  input wire logic hall_u,
  input wire logic hall_v,
  input wire logic hall_w,
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic enc_idx,
  input wire logic net_active,
  output logic [dic_pkg::THR_INPUTS-1:0] thr_sel,
  output logic [NUM_OUT-1:0] dout,
  output logic brake
);
  import dic_pkg::*;

  localparam logic [PRESC_W-1:0] PRESC_RESET = PRESC_W'(TICK_CYCLES - 1);

  typedef struct packed {
    logic [NUM_IN-1:0] in_s1;
    logic [NUM_IN-1:0] in_s2;
    logic [EXT_W-1:0] ext_s1;
    logic [EXT_W-1:0] ext_s2;
    logic [NUM_IN-1:0] raw;
    logic [PRESC_W-1:0] tick_cnt;
    logic tick;
    logic [PRESC_W-1:0] presc;
    logic [WORD_W-1:0] sfe;
    logic [WORD_W-1:0] inv;
    logic [WORD_W-1:0] fen;
    logic [WORD_W-1:0] fval;
    logic [WORD_W-1:0] thr;
    logic [WORD_W-1:0] outc;
    logic route_en;
    logic [ROUTE_ENTRIES-1:0][7:0] route;
    logic [WORD_W-1:0] summary;
    logic a_valid;
    logic a_write;
    logic [7:0] a_idx;
    logic ready;
    logic resp;
    logic [WORD_W-1:0] rdata;
    logic brake;
    logic [NUM_OUT-1:0] outs;
    logic [THR_INPUTS-1:0] thr_out;
  } dic_state_s;

  dic_state_s s_q;
  dic_state_s s_d;
  logic [PHYS_MAX-1:0] phys_now;

  // Map a word index onto a register
  function automatic dic_reg_e decode_reg(input logic [7:0] idx);
    dic_reg_e r;
    r = REG_NONE;
    if (idx >= IDX_ROUTE_FIRST && idx <= IDX_ROUTE_LAST) begin
      r = REG_ROUTE;
    end else begin
      unique case (idx)
        IDX_SFE: r = REG_SFE;
        IDX_INV: r = REG_INV;
        IDX_FEN: r = REG_FEN;
        IDX_FVAL: r = REG_FVAL;
        IDX_RAW: r = REG_RAW;
        IDX_THR: r = REG_THR;
        IDX_RTEN: r = REG_RTEN;
        IDX_SUMM: r = REG_SUMM;
        IDX_OUTC: r = REG_OUTC;
        IDX_PRESC: r = REG_PRESC;
        default: r = REG_NONE;
      endcase
    end
    return r;
  endfunction

  // Value of one route source code
  function automatic logic src_value(input logic [7:0] code, input logic [PHYS_MAX-1:0] phys,
                                     input logic [EXT_W-1:0] ext, input logic net);
    logic v;
    logic [6:0] c;
    c = code[6:0];
    v = 1'b0; // SRC_ZERO and unlisted codes
    if (c >= SRC_PHYS_FIRST && c <= SRC_PHYS_LAST) begin
      v = phys[4'(c - SRC_PHYS_FIRST)];
    end else if (c >= SRC_HALL_U && c <= SRC_ENC_IDX) begin
      v = ext[3'(c - SRC_HALL_U)];
    end else if (c == SRC_NET) begin
      v = net;
    end
    return v ^ code[CODE_INV_BIT];
  endfunction

  // Route code that reproduces one input under the current masks
  function automatic logic [7:0] init_code(input int idx, input logic fe, input logic fv,
                                           input logic iv);
    logic [7:0] c;
    if (fe) begin
      c = {fv ^ iv, SRC_ZERO};
    end else begin
      c = {iv, 7'(SRC_PHYS_FIRST + 7'(idx))};
    end
    return c;
  endfunction

  // Physical inputs widened to the source code range
  assign phys_now = PHYS_MAX'(s_q.in_s2);

  // Next state
  always_comb begin
    logic lvl;
    int e;
    lvl = 1'b0;
    e = 0;
    s_d = s_q;
    // Two-stage synchronisers
    s_d.in_s1 = din_pin;
    s_d.in_s2 = s_q.in_s1;
    s_d.ext_s1 = {enc_idx, enc_b, enc_a, hall_w, hall_v, hall_u};
    s_d.ext_s2 = s_q.ext_s1;
    // Millisecond tick from the prescaler
    s_d.tick = 1'b0;
    if (s_q.tick_cnt == '0) begin
      s_d.tick_cnt = s_q.presc;
      s_d.tick = 1'b1;
    end else begin
      s_d.tick_cnt = s_q.tick_cnt - PRESC_W'(1);
    end
    // Sample and rebuild the whole summary on the tick
    if (s_q.tick) begin
      s_d.raw = s_q.in_s2;
      s_d.summary = WORD_RESET;
      if (s_q.route_en) begin
        for (int b = 0; b < ROUTE_ENTRIES; b++) begin
          s_d.summary[b] = src_value(s_q.route[b], phys_now, s_q.ext_s2, net_active);
        end
      end else begin
        for (int i = 0; i < NUM_IN; i++) begin
          lvl = (s_q.fen[i] ? s_q.fval[i] : phys_now[i]) ^ s_q.inv[i];
          s_d.summary[LEVEL_BASE + i] = lvl;
          s_d.summary[i] = lvl & s_q.sfe[i];
        end
      end
    end
    // Output mapping and threshold selects
    s_d.brake = s_q.outc[BRAKE_BIT];
    for (int k = 0; k < NUM_OUT; k++) begin
      s_d.outs[k] = s_q.outc[LEVEL_BASE + k];
    end
    s_d.thr_out = s_q.thr[THR_INPUTS-1:0];
    // Data phase of a write
    if (s_q.a_valid && s_q.a_write) begin
      unique case (decode_reg(s_q.a_idx))
        REG_SFE: s_d.sfe = hwdata;
        REG_INV: s_d.inv = hwdata;
        REG_FEN: s_d.fen = hwdata;
        REG_FVAL: s_d.fval = hwdata;
        REG_THR: s_d.thr = hwdata;
        REG_OUTC: s_d.outc = hwdata;
        REG_PRESC: s_d.presc = hwdata[PRESC_W-1:0];
        REG_ROUTE: begin
          e = int'(s_q.a_idx - IDX_ROUTE_FIRST);
          s_d.route[e] = hwdata[7:0];
        end
        REG_RTEN: begin
          s_d.route_en = hwdata[ROUTING_EN_BIT];
          if (hwdata[ROUTING_EN_BIT] && !s_q.route_en) begin
            // Table reproduces the normal-mode result
            for (int b = 0; b < ROUTE_ENTRIES; b++) begin
              s_d.route[b] = CODE_RESET;
            end
            for (int i = 0; i < NUM_IN; i++) begin
              s_d.route[LEVEL_BASE + i] = init_code(i, s_q.fen[i], s_q.fval[i], s_q.inv[i]);
              s_d.route[i] = s_q.sfe[i] ? init_code(i, s_q.fen[i], s_q.fval[i], s_q.inv[i])
                                        : CODE_RESET;
            end
          end
        end
        default: ;
      endcase
    end
    // Address phase; read data reflects any write just applied
    s_d.ready = 1'b1;
    s_d.resp = HRESP_OKAY;
    s_d.a_valid = hsel && htrans[1] && hready;
    s_d.a_write = hwrite;
    s_d.a_idx = (haddr[31:10] == '0) ? haddr[9:2] : IDX_NONE;
    s_d.rdata = WORD_RESET;
    if (s_d.a_valid && !hwrite) begin
      unique case (decode_reg(s_d.a_idx))
        REG_SFE: s_d.rdata = s_d.sfe;
        REG_INV: s_d.rdata = s_d.inv;
        REG_FEN: s_d.rdata = s_d.fen;
        REG_FVAL: s_d.rdata = s_d.fval;
        REG_RAW: s_d.rdata = WORD_W'(s_q.raw);
        REG_THR: s_d.rdata = s_d.thr;
        REG_RTEN: s_d.rdata = WORD_W'(s_d.route_en);
        REG_SUMM: s_d.rdata = s_q.summary;
        REG_OUTC: s_d.rdata = s_d.outc;
        REG_PRESC: s_d.rdata = WORD_W'(s_d.presc);
        REG_ROUTE: begin
          e = int'(s_d.a_idx - IDX_ROUTE_FIRST);
          s_d.rdata = WORD_W'(s_d.route[e]);
        end
        default: s_d.rdata = WORD_RESET;
      endcase
    end
  end

  // State register
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
      s_q.tick_cnt <= PRESC_RESET;
      s_q.presc <= PRESC_RESET;
      s_q.ready <= 1'b1;
      s_q.a_idx <= IDX_NONE;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register
  assign hreadyout = s_q.ready;
  assign hresp = s_q.resp;
  assign hrdata = s_q.rdata;
  assign thr_sel = s_q.thr_out;
  assign dout = s_q.outs;
  assign brake = s_q.brake;

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  // Cycles since the last tick, and the reload that the last tick started
  logic [PRESC_W-1:0] gap_cnt;
  logic [PRESC_W-1:0] span_q;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      gap_cnt <= '1;
      span_q <= PRESC_RESET;
    end else begin
      gap_cnt <= s_q.tick ? '0 : gap_cnt + PRESC_W'(1);
      if (s_q.tick) begin
        span_q <= s_q.tick_cnt;
      end
    end
  end

  // Tick timing; reload value may change mid-period
  a_tick_spacing: assert property (
    s_q.tick |-> gap_cnt == span_q)
    else $error("tick spacing differs from prescaler");
  a_tick_too_early: assert property (
    !s_q.tick && (gap_cnt + PRESC_W'(1)) < span_q |=> !s_q.tick)
    else $error("tick before prescaler expired");

  // Sampling and the summary word
  a_raw_on_tick: assert property (
    s_q.tick |=> s_q.raw == $past(s_q.in_s2))
    else $error("raw levels not sampled on tick");
  a_summary_hold: assert property (
    !s_q.tick |=> $stable(s_q.summary) && $stable(s_q.raw))
    else $error("summary changed between ticks");
  a_level_bit_one: assert property (
    s_q.tick && !s_q.route_en |=> s_q.summary[LEVEL_BASE] ==
      (($past(s_q.fen[0]) ? $past(s_q.fval[0]) : $past(s_q.in_s2[0])) ^ $past(s_q.inv[0])))
    else $error("input 1 level bit wrong");
  a_forced_level: assert property (
    s_q.tick && !s_q.route_en && s_q.fen[SF_POS_LIMIT] |=> s_q.summary[LEVEL_BASE + SF_POS_LIMIT] ==
      ($past(s_q.fval[SF_POS_LIMIT]) ^ $past(s_q.inv[SF_POS_LIMIT])))
    else $error("forced input 2 not taken from force value");
  a_sf_masked: assert property (
    s_q.tick && !s_q.route_en && !s_q.sfe[SF_HOME] |=> !s_q.summary[SF_HOME])
    else $error("disabled special bit set");
  a_special_gate: assert property (
    s_q.tick && !s_q.route_en |=> s_q.summary[NUM_IN-1:0] ==
      (s_q.summary[LEVEL_BASE +: NUM_IN] & $past(s_q.sfe[NUM_IN-1:0])))
    else $error("special bits differ from gated level bits");

  // Routing mode entry, exit and table
  a_route_mode: assert property (
    s_q.a_valid && s_q.a_write && decode_reg(s_q.a_idx) == REG_RTEN |=>
      s_q.route_en == $past(hwdata[ROUTING_EN_BIT]))
    else $error("routing enable not taken from write");
  a_route_stays: assert property (
    s_q.route_en && !(s_q.a_valid && s_q.a_write) |=> s_q.route_en)
    else $error("routing left without a write");
  a_route_load: assert property (
    s_q.a_valid && s_q.a_write && decode_reg(s_q.a_idx) == REG_RTEN &&
      hwdata[ROUTING_EN_BIT] && !s_q.route_en && !s_q.fen[0] |=>
      s_q.route[LEVEL_BASE] == {$past(s_q.inv[0]), SRC_PHYS_FIRST})
    else $error("route table not loaded on entry");
  a_route_level: assert property (
    s_q.tick && s_q.route_en && s_q.route[LEVEL_BASE][6:0] == SRC_PHYS_FIRST |=>
      s_q.summary[LEVEL_BASE] ==
      ($past(s_q.in_s2[0]) ^ $past(s_q.route[LEVEL_BASE][CODE_INV_BIT])))
    else $error("bit 16 does not follow its route entry");

  // Routing sources
  a_route_const_one: assert property (
    s_q.tick && s_q.route_en && s_q.route[0] == {1'b1, SRC_ZERO} |=> s_q.summary[0])
    else $error("code 80 did not give one");
  a_route_zero: assert property (
    s_q.tick && s_q.route_en && s_q.route[ROUTE_ENTRIES-1] == CODE_RESET |=>
      !s_q.summary[ROUTE_ENTRIES-1])
    else $error("code 00 did not give zero");
  a_route_phys: assert property (
    s_q.tick && s_q.route_en && s_q.route[0] == {1'b0, SRC_PHYS_FIRST} |=>
      s_q.summary[0] == $past(s_q.in_s2[0]))
    else $error("input code did not select input 1");
  a_route_hall: assert property (
    s_q.tick && s_q.route_en && s_q.route[0] == {1'b0, SRC_HALL_U} |=>
      s_q.summary[0] == $past(s_q.ext_s2[0]))
    else $error("hall code did not select hall line");
  a_route_net: assert property (
    s_q.tick && s_q.route_en && s_q.route[0] == {1'b0, SRC_NET} |=>
      s_q.summary[0] == $past(net_active))
    else $error("network code did not select status");

  // Output pins follow their control bits one cycle later; bus response always ready and okay
  a_brake_map: assert property (
    1'b1 |=> brake == $past(s_q.outc[BRAKE_BIT]))
    else $error("brake does not follow control bit");
  a_out_one_map: assert property (
    1'b1 |=> dout == $past(s_q.outc[LEVEL_BASE +: NUM_OUT]))
    else $error("outputs do not follow bits 16 up");
  a_thr_map: assert property (
    1'b1 |=> thr_sel == $past(s_q.thr[THR_INPUTS-1:0]))
    else $error("threshold selects do not follow mask");
  a_bus_okay: assert property (
    hreadyout && hresp == HRESP_OKAY)
    else $error("bus response not ready and okay");

  c_route_tick: cover property (s_q.tick && s_q.route_en);
  c_route_enter: cover property ($rose(s_q.route_en));
  c_forced_tick: cover property (s_q.tick && !s_q.route_en && s_q.fen[0]);
  c_inverted_code: cover property (s_q.tick && s_q.route_en && s_q.route[0][CODE_INV_BIT]);
endmodule

// ===== dic_pin_model.sv
// Purpose: Switch, Hall and encoder lines seen by the conditioning block
// Assumes: Levels change only just after a rising clock edge
// Notes: Bench chooses each level; lines hold like real switches
`timescale 1ns/1ps
module dic_pin_model (
  input wire logic core_clk,
  input wire logic [12:0] set_lvl,
  output logic [5:0] din_pin,
  output logic hall_u,
  output logic hall_v,
  output logic hall_w,
  output logic enc_a,
  output logic enc_b,
  output logic enc_idx,
  output logic net_active
);
  // Lines take the chosen levels one cycle after the bench sets them
  always @(posedge core_clk) begin
    {net_active, enc_idx, enc_b, enc_a, hall_w, hall_v, hall_u, din_pin} <= set_lvl;
  end
endmodule

// ===== tb.sv
// Purpose: Register level test of input conditioning, routing and outputs
// Assumes: Zero wait AHB-Lite slave, short tick for simulation
// Notes: Summary is read after two tick periods so new levels land
`timescale 1ns/1ps
module tb;
  import dic_pkg::*;
  localparam int TICKS = 20;
  localparam int SETTLE = 2 * (TICKS + 4);
  localparam int LIMIT = 6000;
  logic core_clk, rst_b, hsel, hwrite, hreadyout, hresp, brake;
  logic hall_u, hall_v, hall_w, enc_a, enc_b, enc_idx, net_active;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rv;
  logic [12:0] set_lvl;
  logic [5:0] din_pin;
  logic [3:0] thr_sel, dout;
  logic [7:0] codes [14] = '{8'h00, 8'h80, 8'h01, 8'h02, 8'h83, 8'h41, 8'h42,
    8'h43, 8'h44, 8'h45, 8'h46, 8'h48, 8'hC8, 8'hC2};
  bit exp_b [14] = '{0, 1, 1, 0, 0, 1, 0, 1, 0, 1, 1, 1, 0, 1};
  int mismatches, cmp_count, cyc;
  dic_top #(.NUM_IN(6), .NUM_OUT(4), .TICK_CYCLES(TICKS)) dic_top_i (
    .core_clk(core_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .din_pin(din_pin),
    .hall_u(hall_u), .hall_v(hall_v), .hall_w(hall_w), .enc_a(enc_a), .enc_b(enc_b),
    .enc_idx(enc_idx), .net_active(net_active), .thr_sel(thr_sel), .dout(dout),
    .brake(brake));
  dic_pin_model dic_pin_model_i (
    .core_clk(core_clk), .set_lvl(set_lvl), .din_pin(din_pin), .hall_u(hall_u),
    .hall_v(hall_v), .hall_w(hall_w), .enc_a(enc_a), .enc_b(enc_b),
    .enc_idx(enc_idx), .net_active(net_active));
  // Clock at 100 ns period
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // Hang guard
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      mismatches = mismatches + 1;
      final_report();
    end
  end
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count = cmp_count + 1;
    if (seen !== exp) begin
      mismatches = mismatches + 1;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // One single AHB-Lite transfer, held until hready is seen high
  task automatic ahb(input logic w, input logic [7:0] idx, input logic [31:0] d);
    @(posedge core_clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {22'h00_0000, idx, 2'b00};
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    rv = hrdata;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    ahb(1'b1, idx, d);
  endtask
  task automatic rd(input string name, input logic [7:0] idx, input logic [31:0] exp);
    ahb(1'b0, idx, 32'h0000_0000);
    check(name, rv, exp);
  endtask
  task automatic settle();
    repeat (SETTLE) @(posedge core_clk);
  endtask
  // Main sequence
  initial begin
    mismatches = 0;
    cmp_count = 0;
    cyc = 0;
    rst_b = 1'b0;
    hsel = 1'b0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    haddr = 32'h0000_0000;
    hwdata = 32'h0000_0000;
    set_lvl = 13'b1_1101_0100_0101;
    repeat (5) @(posedge core_clk);
    rst_b <= 1'b1;
    rd("sfe reset", IDX_SFE, 32'h0000_0000);
    rd("unmapped", 8'h40, 32'h0000_0000);
    check("hresp", {31'h0, hresp}, {31'h0, HRESP_OKAY});
    check("hreadyout", {31'h0, hreadyout}, 32'h0000_0001);
    // Output mapping and threshold select
    wr(IDX_OUTC, 32'h000F_0001);
    wr(IDX_THR, 32'h0000_0005);
    repeat (2) @(posedge core_clk);
    check("dout", {28'h0, dout}, 32'h0000_000F);
    check("brake", {31'h0, brake}, 32'h0000_0001);
    check("thr_sel", {28'h0, thr_sel}, 32'h0000_0005);
    rd("outc", IDX_OUTC, 32'h000F_0001);
    wr(IDX_OUTC, 32'h0002_0000);
    repeat (2) @(posedge core_clk);
    check("dout one", {28'h0, dout}, 32'h0000_0002);
    check("brake off", {31'h0, brake}, 32'h0000_0000);
    // Normal mode: inputs 1 and 3 high
    settle();
    rd("summary masked", IDX_SUMM, 32'h0005_0000);
    rd("raw", IDX_RAW, 32'h0000_0005);
    wr(IDX_SFE, 32'h0000_003F);
    settle();
    rd("summary enabled", IDX_SUMM, 32'h0005_0005);
    wr(IDX_INV, 32'h0000_0001);
    settle();
    rd("summary inverted", IDX_SUMM, 32'h0004_0004);
    wr(IDX_FEN, 32'h0000_0002);
    wr(IDX_FVAL, 32'h0000_0002);
    settle();
    rd("summary forced", IDX_SUMM, 32'h0006_0006);
    rd("raw unforced", IDX_RAW, 32'h0000_0005);
    // Enter routing: table reproduces previous behaviour
    wr(IDX_RTEN, 32'h0000_0001);
    rd("entry 17", 8'h51, 32'h0000_0081);
    rd("entry 18", 8'h52, 32'h0000_0080);
    rd("entry 19", 8'h53, 32'h0000_0003);
    rd("entry 1", 8'h41, 32'h0000_0081);
    rd("entry 32", 8'h60, 32'h0000_0000);
    settle();
    rd("summary routed", IDX_SUMM, 32'h0006_0006);
    wr(IDX_INV, 32'h0000_0000);
    wr(IDX_FEN, 32'h0000_0000);
    wr(IDX_SFE, 32'h0000_0000);
    settle();
    rd("masks ignored", IDX_SUMM, 32'h0006_0006);
    // Source codes on summary bit 0: zero, one, inputs 1-3, all Hall/encoder lines, network
    for (int i = 0; i < 14; i++) begin
      wr(8'h41, {24'h00_0000, codes[i]});
      settle();
      ahb(1'b0, IDX_SUMM, 32'h0000_0000);
      check("code bit", {31'h0, rv[0]}, {31'h0, exp_b[i]});
    end
    wr(8'h51, 32'h0000_0002);
    settle();
    rd("bit 16 input 2", IDX_SUMM, 32'h0006_0007);
    wr(8'h51, 32'h0000_0003);
    settle();
    rd("bit 16 input 3", IDX_SUMM, 32'h0007_0007);
    // Leave routing: masks act again
    wr(IDX_SFE, 32'h0000_003F);
    wr(IDX_RTEN, 32'h0000_0000);
    settle();
    rd("summary normal", IDX_SUMM, 32'h0005_0005);
    set_lvl <= 13'b1_1101_0110_0000;
    settle();
    rd("input 6", IDX_SUMM, 32'h0020_0020);
    rd("raw input 6", IDX_RAW, 32'h0000_0020);
    wr(IDX_PRESC, 32'h0000_0027);
    rd("prescaler", IDX_PRESC, 32'h0000_0027);
    final_report();
  end
endmodule
